/* File: include/dcd_pkg.sv */
// Purpose: Shared constants and carrier types for the configuration decoder
// Assumes: 32-bit APB, word-aligned registers
// Notes: Configuration bit positions follow the stored word layout
package dcd_pkg;
  localparam logic [11:0] DCD_OFF_CFG1 = 12'h000;
  localparam logic [11:0] DCD_OFF_CFG2 = 12'h004;
  localparam logic [11:0] DCD_OFF_CFG3 = 12'h008;
  localparam logic [11:0] DCD_OFF_CTRL = 12'h00C;
  localparam logic [11:0] DCD_OFF_IDENT = 12'h010;
  localparam logic [11:0] DCD_OFF_UNLOCK = 12'h014;
  localparam logic [11:0] DCD_OFF_REMAP = 12'h018;
  localparam logic [11:0] DCD_OFF_MODDIS = 12'h01C;
  localparam logic [31:0] DCD_UNLOCK_KEY1 = 32'hAA996655;
  localparam logic [31:0] DCD_UNLOCK_KEY2 = 32'h556699AA;
  // Arbitrary neutral identity values
  localparam logic [3:0] DCD_REVISION = 4'h1;
  localparam logic [27:0] DCD_PART_IDENT = 28'h0000001;
  localparam int DCD_CTRL_REMAP_LOCK = 13;
  localparam int DCD_CTRL_MODDIS_LOCK = 12;
  localparam int DCD_CTRL_JTAG = 3;
  localparam int DCD_CTRL_TRACE = 2;
  localparam int DCD_CTRL_TDO = 0;
  localparam logic [31:0] DCD_CTRL_MASK = 32'h0000300D;
  localparam int DCD_CFG0_JTAG = 2;
  localparam logic [4:0] DCD_POSTSCALE_MAX = 5'h14;
  localparam logic [1:0] DCD_POSC_EXT = 2'h0;
  localparam logic [1:0] DCD_POSC_OFF = 2'h3;
  localparam logic [2:0] DCD_LOAD_WORDS = 3'h4;

  typedef enum logic [1:0] {
    DCD_WIN_75 = 2'h0,
    DCD_WIN_50 = 2'h1,
    DCD_WIN_37_5 = 2'h2,
    DCD_WIN_25 = 2'h3
  } dcd_window_t;

  typedef enum logic [1:0] {
    DCD_POSC_EXTERNAL = 2'h0,
    DCD_POSC_MEDIUM = 2'h1,
    DCD_POSC_HIGH = 2'h2,
    DCD_POSC_DISABLED = 2'h3
  } dcd_posc_t;

  typedef enum logic [2:0] {
    DCD_SRC_FRC = 3'h0,
    DCD_SRC_FRC_DIV_PLL = 3'h1,
    DCD_SRC_PRIMARY = 3'h2,
    DCD_SRC_PRIMARY_PLL = 3'h3,
    DCD_SRC_SECONDARY = 3'h4,
    DCD_SRC_LOW_POWER_RC_OSCILLATOR = 3'h5,
    DCD_SRC_FRC_DIV16 = 3'h6,
    DCD_SRC_FRC_DIV = 3'h7
  } dcd_src_t;

  typedef enum logic [2:0] {
    DCD_ST_RESET = 3'b000,
    DCD_ST_FETCH = 3'b001,
    DCD_ST_WAIT = 3'b011,
    DCD_ST_RUN = 3'b010
  } dcd_state_t;

  typedef struct packed {
    dcd_window_t window_size;
    logic force_on;
    logic window_off;
    logic [20:0] postscale_ratio_log2_onehot;
  } dcd_wdt_t;

  typedef struct packed {
    logic switch_enable;
    logic monitor_enable;
    logic [3:0] periph_bus_div;
    logic clock_out_enable;
    dcd_posc_t posc_mode;
    logic two_speed_startup;
    logic secondary_osc_enable;
    dcd_src_t startup_src;
  } dcd_clk_t;

  typedef struct packed {
    logic [8:0] sys_out_div;
    logic usb_pll_bypass;
    logic [3:0] usb_in_div;
    logic [3:0] sys_in_div;
    logic [4:0] sys_mult;
  } dcd_pll_t;

  typedef struct packed {
    logic vbus_on_usb;
    logic usb_id_usb;
    logic pin_remap_one_shot;
    logic module_disable_one_shot;
    logic [15:0] user_ident_field;
  } dcd_pins_t;
endpackage

/* File: core/dcd_store.sv */
// Purpose: Small storage for the nonvolatile configuration words
// Assumes: Contents come from nonvolatile storage on the nv_image input
// Notes: Read data registered, one cycle latency
`timescale 1ns/100ps
module dcd_store
  import dcd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] rd_addr,
  output logic [31:0] rd_data,
  input wire logic [127:0] nv_image
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= 32'h00000000;
    end else begin
      rd_data <= nv_image[32*rd_addr +: 32];
    end
  end
endmodule

/* File: core/dcd_top.sv */
// Purpose: Configuration word loader and decoder with APB register view
// Assumes: nv_image stable while the block loads after reset
// Notes: Words 0..3 at nv_image bits 31:0..127:96
// Overview of operation
// R01: Window size 11=25%, 10=37.5%, 01=50%, 00=75%.
// R02: Force-on bit set keeps watchdog on; clear leaves it to software.
// R03: Window-off bit set gives non-window mode, clear gives windowed.
// R04: Postscale code n up to 10100 gives 2^n; others act as 10100.
// R05: Switch field 1x disables both, 01 switching only, 00 both on.
// R06: Peripheral bus clock is system clock over 1, 2, 4 or 8.
// R07: Clock out active when bit clear and primary mode off or external.
// R08: Primary mode 11 off, 10 high speed, 01 medium, 00 external.
// R09: Two-speed start-up follows its configuration bit.
// R10: Secondary oscillator enable follows its configuration bit.
// R11: Start-up source field selects one of eight oscillator sources.
// R12: Programmer must not disable primary while it is the source.
// R13: System PLL output divisor 1,2,4,8,16,32,64,256.
// R14: USB PLL bit 1 bypasses the PLL, 0 enables it.
// R15: Both PLL input dividers: 1,2,3,4,5,6,10,12.
// R16: System PLL multiplier 15..21 then 24.
// R17: Pin owner bits give VBUS-on and ID pins to USB when set.
// R18: One-shot bits allow one lock reconfiguration when set.
// R19: Sixteen-bit user identifier held and readable.
// R20: Locks block remap and module-disable writes; unlock needed to change.
// R21: Control bits: jtag enable, trace enable, two-wire TDO reset 1.
// R22: Identification register read-only: revision 31:28, part 27:0.
// R23: Word 0 jtag bit gives control jtag enable reset value.
// R24: Words loaded after reset before settings are released, then frozen.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module dcd_top
  import dcd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [127:0] nv_image,
  output logic config_valid,
  output dcd_wdt_t wdt_cfg,
  output dcd_clk_t clk_cfg,
  output dcd_pll_t pll_cfg,
  output dcd_pins_t pins_cfg,
  output logic pin_remap_lock,
  output logic module_disable_lock,
  output logic jtag_port_enable,
  output logic trace_output_enable,
  output logic two_wire_tdo_use,
  output logic [31:0] pin_remap_q,
  output logic [31:0] module_disable_q
);
  dcd_state_t state_q;
  logic [2:0] idx_q;
  logic [1:0] rd_addr;
  logic [31:0] rd_data;
  logic [31:0] cfg0_q, cfg1_q, cfg2_q, cfg3_q;
  logic [1:0] unlock_q;
  logic remap_used_q, moddis_used_q;
  logic wr_en, rd_en, unlocked;
  logic [31:0] rd_mux;
  logic rd_err;
  logic [20:0] post_onehot;

  assign rd_addr = idx_q[1:0];

  dcd_store u_store (
    .pclk(pclk),
    .presetn(presetn),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .nv_image(nv_image)
  );

  // R24 load sequence
  // Two edges per word: address out, then registered word back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= DCD_ST_RESET;
      idx_q <= 3'h0;
    end else begin
      case (state_q)
        DCD_ST_RESET: begin
          state_q <= DCD_ST_FETCH;
          idx_q <= 3'h0;
        end
        DCD_ST_FETCH: begin
          state_q <= DCD_ST_WAIT;
        end
        DCD_ST_WAIT: begin
          idx_q <= idx_q + 3'h1;
          if (idx_q + 3'h1 == DCD_LOAD_WORDS) begin
            state_q <= DCD_ST_RUN;
          end else begin
            state_q <= DCD_ST_FETCH;
          end
        end
        default: begin
          state_q <= DCD_ST_RUN;
        end
      endcase
    end
  end

  // R24 words frozen once captured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg0_q <= 32'hFFFFFFFF;
      cfg1_q <= 32'hFFFFFFFF;
      cfg2_q <= 32'hFFFFFFFF;
      cfg3_q <= 32'h00000000;
    end else if (state_q == DCD_ST_WAIT) begin
      case (idx_q[1:0])
        2'h0: cfg0_q <= rd_data;
        2'h1: cfg1_q <= rd_data;
        2'h2: cfg2_q <= rd_data;
        default: cfg3_q <= rd_data & 32'hF000FFFF;
      endcase
    end
  end

  // High the edge after the last word lands; structs settle with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_valid <= 1'b0;
    end else begin
      config_valid <= (state_q == DCD_ST_RUN);
    end
  end

  // R04 one match per ratio bit; codes past 10100 fold onto the top bit
  for (genvar n = 0; n <= int'(DCD_POSTSCALE_MAX); n++) begin : g_post
    if (n == int'(DCD_POSTSCALE_MAX)) begin : g_top
      assign post_onehot[n] = (cfg1_q[20:16] >= DCD_POSTSCALE_MAX);
    end else begin : g_low
      assign post_onehot[n] = (cfg1_q[20:16] == 5'(n));
    end
  end

  // Decoded settings, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cfg <= '0;
      clk_cfg <= '0;
      pll_cfg <= '0;
      pins_cfg <= '0;
    end else begin
      // R01 window size code
      wdt_cfg.window_size <= dcd_window_t'(cfg1_q[25:24]);
      // R02 force-on
      wdt_cfg.force_on <= cfg1_q[23];
      // R03 window mode
      wdt_cfg.window_off <= cfg1_q[22];
      // R04 postscale one-hot
      wdt_cfg.postscale_ratio_log2_onehot <= post_onehot;
      // R05 switching and monitor
      clk_cfg.switch_enable <= ~cfg1_q[15];
      clk_cfg.monitor_enable <= ~cfg1_q[15] & ~cfg1_q[14];
      // R06 bus divisor
      clk_cfg.periph_bus_div <= 4'h1 << cfg1_q[13:12];
      // R07 clock output gating
      clk_cfg.clock_out_enable <= ~cfg1_q[10] &
        ((cfg1_q[9:8] == DCD_POSC_OFF) || (cfg1_q[9:8] == DCD_POSC_EXT));
      // R08 primary mode
      clk_cfg.posc_mode <= dcd_posc_t'(cfg1_q[9:8]);
      // R09 two-speed
      clk_cfg.two_speed_startup <= cfg1_q[7];
      // R10 secondary oscillator
      clk_cfg.secondary_osc_enable <= cfg1_q[5];
      // R11 start-up source; R12 primary-off conflict is the programmer's duty
      clk_cfg.startup_src <= dcd_src_t'(cfg1_q[2:0]);
      // R13 output divisor
      pll_cfg.sys_out_div <= out_div(cfg2_q[18:16]);
      // R14 USB PLL bypass
      pll_cfg.usb_pll_bypass <= cfg2_q[15];
      // R15 input dividers
      pll_cfg.usb_in_div <= in_div(cfg2_q[10:8]);
      pll_cfg.sys_in_div <= in_div(cfg2_q[2:0]);
      // R16 multiplier
      pll_cfg.sys_mult <= pll_mult(cfg2_q[6:4]);
      // R17 pin ownership; R18 one-shot policy; R19 user identifier
      pins_cfg <= {cfg3_q[31:28], cfg3_q[15:0]};
    end
  end

  // R15 one table shared by both input dividers
  function automatic logic [3:0] in_div(input logic [2:0] code);
    case (code)
      3'h0: in_div = 4'h1;
      3'h1: in_div = 4'h2;
      3'h2: in_div = 4'h3;
      3'h3: in_div = 4'h4;
      3'h4: in_div = 4'h5;
      3'h5: in_div = 4'h6;
      3'h6: in_div = 4'hA;
      default: in_div = 4'hC;
    endcase
  endfunction

  // Code 111 jumps to 256; no divide by 128 exists
  function automatic logic [8:0] out_div(input logic [2:0] code);
    case (code)
      3'h0: out_div = 9'h001;
      3'h1: out_div = 9'h002;
      3'h2: out_div = 9'h004;
      3'h3: out_div = 9'h008;
      3'h4: out_div = 9'h010;
      3'h5: out_div = 9'h020;
      3'h6: out_div = 9'h040;
      default: out_div = 9'h100;
    endcase
  endfunction

  // Code 111 jumps to 24; 22 and 23 are not offered
  function automatic logic [4:0] pll_mult(input logic [2:0] code);
    case (code)
      3'h0: pll_mult = 5'h0F;
      3'h1: pll_mult = 5'h10;
      3'h2: pll_mult = 5'h11;
      3'h3: pll_mult = 5'h12;
      3'h4: pll_mult = 5'h13;
      3'h5: pll_mult = 5'h14;
      3'h6: pll_mult = 5'h15;
      default: pll_mult = 5'h18;
    endcase
  endfunction

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign unlocked = (unlock_q == 2'h2);

  // Unlock key sequence; any other write to the unlock word re-arms it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_q <= 2'h0;
    end else if (wr_en && paddr == DCD_OFF_UNLOCK) begin
      if (pwdata == DCD_UNLOCK_KEY1) begin
        unlock_q <= 2'h1;
      end else if (pwdata == DCD_UNLOCK_KEY2 && unlock_q == 2'h1) begin
        unlock_q <= 2'h2;
      end else begin
        unlock_q <= 2'h0;
      end
    end
  end

  // R21 debug bits; R23 jtag reset value taken from word 0 at load
  // Software writes are dropped until the loader is done so the word 0 value is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jtag_port_enable <= 1'b0;
      trace_output_enable <= 1'b0;
      two_wire_tdo_use <= 1'b1;
    end else if (state_q == DCD_ST_WAIT && idx_q[1:0] == 2'h0) begin
      jtag_port_enable <= rd_data[DCD_CFG0_JTAG];
    end else if (wr_en && paddr == DCD_OFF_CTRL && state_q == DCD_ST_RUN) begin
      jtag_port_enable <= pwdata[DCD_CTRL_JTAG];
      trace_output_enable <= pwdata[DCD_CTRL_TRACE];
      two_wire_tdo_use <= pwdata[DCD_CTRL_TDO];
    end
  end

  // R20 locks change only after unlock; R18 one-shot limits to one change
  // Used flag records a set only; a clear never spends the one shot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_remap_lock <= 1'b0;
      module_disable_lock <= 1'b0;
      remap_used_q <= 1'b0;
      moddis_used_q <= 1'b0;
    end else if (wr_en && paddr == DCD_OFF_CTRL && unlocked) begin
      if (!(pins_cfg.pin_remap_one_shot && remap_used_q) &&
          pwdata[DCD_CTRL_REMAP_LOCK] != pin_remap_lock) begin
        pin_remap_lock <= pwdata[DCD_CTRL_REMAP_LOCK];
        remap_used_q <= pwdata[DCD_CTRL_REMAP_LOCK];
      end
      if (!(pins_cfg.module_disable_one_shot && moddis_used_q) &&
          pwdata[DCD_CTRL_MODDIS_LOCK] != module_disable_lock) begin
        module_disable_lock <= pwdata[DCD_CTRL_MODDIS_LOCK];
        moddis_used_q <= pwdata[DCD_CTRL_MODDIS_LOCK];
      end
    end
  end

  // R20 guarded remap and module-disable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_remap_q <= 32'h00000000;
      module_disable_q <= 32'h00000000;
    end else if (wr_en) begin
      if (paddr == DCD_OFF_REMAP && !pin_remap_lock) begin
        pin_remap_q <= pwdata;
      end
      if (paddr == DCD_OFF_MODDIS && !module_disable_lock) begin
        module_disable_q <= pwdata;
      end
    end
  end

  // Read decode; R22 identification is read-only
  always_comb begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    if (paddr == DCD_OFF_CFG1) begin
      rd_mux = cfg1_q;
    end else if (paddr == DCD_OFF_CFG2) begin
      rd_mux = cfg2_q;
    end else if (paddr == DCD_OFF_CFG3) begin
      rd_mux = cfg3_q;
    end else if (paddr == DCD_OFF_CTRL) begin
      rd_mux = {18'h0, pin_remap_lock, module_disable_lock, 8'h0,
        jtag_port_enable, trace_output_enable, 1'b0, two_wire_tdo_use} & DCD_CTRL_MASK;
    end else if (paddr == DCD_OFF_IDENT) begin
      rd_mux = {DCD_REVISION, DCD_PART_IDENT};
    end else if (paddr == DCD_OFF_UNLOCK) begin
      rd_mux = 32'h00000000;
    end else if (paddr == DCD_OFF_REMAP) begin
      rd_mux = pin_remap_q;
    end else if (paddr == DCD_OFF_MODDIS) begin
      rd_mux = module_disable_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  // Registered answer: ready in every access phase, error on unmapped
  // Writes to read-only words are dropped without an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & rd_err;
      if (rd_en) begin
        prdata <= rd_mux;
      end
    end
  end
endmodule

/* File: testbench/dcd_top_assertions.sv */
// Purpose: Port-level checks on the configuration decoder
// Assumes: nv_image held stable from reset onwards
// Notes: Decode checks hold only while config_valid is high
`timescale 1ns/100ps
module dcd_chk
  import dcd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [127:0] nv_image,
  input wire logic config_valid,
  input wire dcd_wdt_t wdt_cfg,
  input wire dcd_clk_t clk_cfg,
  input wire dcd_pll_t pll_cfg,
  input wire dcd_pins_t pins_cfg,
  input wire logic pin_remap_lock,
  input wire logic module_disable_lock,
  input wire logic jtag_port_enable,
  input wire logic [31:0] pin_remap_q,
  input wire logic [31:0] module_disable_q
);
  localparam logic [3:0] IDIV [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hA, 4'hC};
  localparam logic [4:0] MUL [8] = '{5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h18};
  logic [31:0] w1, w2, w3;
  logic acc;
  assign w1 = nv_image[63:32];
  assign w2 = nv_image[95:64];
  assign w3 = nv_image[127:96];
  assign acc = psel && penable && pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wdt;
    config_valid |-> wdt_cfg.window_size == w1[25:24] && wdt_cfg.force_on == w1[23] && wdt_cfg.window_off == w1[22];
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog decode wrong");
  property p_post;
    config_valid |-> wdt_cfg.postscale_ratio_log2_onehot == 21'h1 << (w1[20:16] > 5'h14 ? 5'h14 : w1[20:16]);
  endproperty
  a_post: assert property (p_post) else $error("postscale decode wrong");
  property p_clk;
    config_valid |-> clk_cfg.switch_enable == !w1[15] && clk_cfg.monitor_enable == (w1[15:14] == 2'h0)
      && clk_cfg.periph_bus_div == 4'h1 << w1[13:12];
  endproperty
  a_clk: assert property (p_clk) else $error("clock switch or divisor wrong");
  property p_osc;
    config_valid |-> clk_cfg.clock_out_enable == (!w1[10] && (w1[9:8] == 2'h0 || w1[9:8] == 2'h3))
      && clk_cfg.posc_mode == w1[9:8] && clk_cfg.two_speed_startup == w1[7]
      && clk_cfg.secondary_osc_enable == w1[5] && clk_cfg.startup_src == w1[2:0];
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator decode wrong");
  property p_pll;
    config_valid |-> pll_cfg.sys_out_div == (w2[18:16] == 3'h7 ? 9'h100 : 9'h1 << w2[18:16])
      && pll_cfg.usb_pll_bypass == w2[15] && pll_cfg.usb_in_div == IDIV[w2[10:8]]
      && pll_cfg.sys_in_div == IDIV[w2[2:0]] && pll_cfg.sys_mult == MUL[w2[6:4]];
  endproperty
  a_pll: assert property (p_pll) else $error("pll decode wrong");
  property p_pins;
    config_valid |-> pins_cfg == {w3[31:28], w3[15:0]};
  endproperty
  a_pins: assert property (p_pins) else $error("pin owner or user id wrong");
  property p_frz;
    config_valid |=> config_valid && $stable({wdt_cfg, clk_cfg, pll_cfg, pins_cfg});
  endproperty
  a_frz: assert property (p_frz) else $error("settings changed after load");
  property p_jtag;
    $rose(config_valid) |-> jtag_port_enable == nv_image[DCD_CFG0_JTAG];
  endproperty
  a_jtag: assert property (p_jtag) else $error("jtag enable not from word 0");
  property p_rlock;
    acc && paddr == DCD_OFF_REMAP && pin_remap_lock |=> $stable(pin_remap_q);
  endproperty
  a_rlock: assert property (p_rlock) else $error("remap written while locked");
  property p_mlock;
    acc && paddr == DCD_OFF_MODDIS && module_disable_lock |=> $stable(module_disable_q);
  endproperty
  a_mlock: assert property (p_mlock) else $error("module disable written while locked");
  property p_id;
    psel && penable && pready && !pwrite && paddr == DCD_OFF_IDENT |-> prdata == {DCD_REVISION, DCD_PART_IDENT};
  endproperty
  a_id: assert property (p_id) else $error("identification read wrong");
  c_load: cover property ($rose(config_valid));
  c_rlock: cover property (acc && paddr == DCD_OFF_REMAP && pin_remap_lock);
  c_mlock: cover property (acc && paddr == DCD_OFF_MODDIS && module_disable_lock);
endmodule

bind dcd_top dcd_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .nv_image,
  .config_valid, .wdt_cfg, .clk_cfg, .pll_cfg, .pins_cfg, .pin_remap_lock, .module_disable_lock,
  .jtag_port_enable, .pin_remap_q, .module_disable_q);

/* File: testbench/tb_device_config_decode.sv */
// Purpose: Register and decode tests for the configuration decoder
// Assumes: Loader done within 40 cycles of reset release
// Notes: Images keep the primary oscillator on whenever it is the start-up source
`timescale 1ns/100ps
module tb_device_config_decode
  import dcd_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, e, config_valid, pready, pslverr;
  logic pin_remap_lock, module_disable_lock, jtag_port_enable, trace_output_enable, two_wire_tdo_use;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, w0, w1, w2, w3, pin_remap_q, module_disable_q;
  logic [127:0] nv_image;
  logic [2:0] k;
  dcd_wdt_t wdt_cfg;
  dcd_clk_t clk_cfg;
  dcd_pll_t pll_cfg;
  dcd_pins_t pins_cfg;
  int bad_count = 0;
  int n_tests = 0;
  logic [4:0] mul [8] = '{5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h18};

  dcd_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .nv_image, .config_valid, .wdt_cfg, .clk_cfg, .pll_cfg, .pins_cfg, .pin_remap_lock, .module_disable_lock,
    .jtag_port_enable, .trace_output_enable, .two_wire_tdo_use, .pin_remap_q, .module_disable_q);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // Leading edge keeps back-to-back calls from driving twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd_v,
    output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd_v = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, 32'h0);
  endtask

  task automatic rst(input logic [127:0] img, input int cyc);
    int n;
    n = 0;
    @(posedge pclk);
    presetn <= 1'b0;
    nv_image <= img;
    repeat (cyc) @(posedge pclk);
    presetn <= 1'b1;
    while (config_valid !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, config_valid}, 32'h1);
  endtask

  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    conclude();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    nv_image = '0;
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      w0 = {29'h0, k[0], 2'h0};
      // sources 010 and 011 pair with primary modes 01 and 00 only
      w1 = {6'h3F, k[1:0], k[0], k[1], 1'b1, k, 2'h0, k[1:0], k[1:0], 1'b1, k[2], ~k[1:0], k[0], 1'b1, k[1], 2'h3, k};
      w2 = {13'h1FFF, k, k[0], 4'hF, k, 1'b1, k, 1'b1, k};
      w3 = {k[0], k[1], k[2], ~k[0], 12'h0, 13'h0A5C, k};
      rst({w3, w2, w1, w0}, i == 0 ? 11 : 3);
      rd(DCD_OFF_CFG1, w1);
      rd(DCD_OFF_CFG2, w2);
      rd(DCD_OFF_CFG3, w3);
      rd(DCD_OFF_CTRL, {28'h0, k[0], 3'h1});
      chk(32'(wdt_cfg.postscale_ratio_log2_onehot), 32'h1 << (k > 3'h4 ? 20 : 4 * i));
      chk({31'h0, clk_cfg.clock_out_enable}, {31'h0, !k[2] && (k[1:0] == 2'h0 || k[1:0] == 2'h3)});
      chk({27'h0, pll_cfg.sys_mult}, {27'h0, mul[k]});
    end
    $display("test decode done");
    wr(DCD_OFF_IDENT, 32'hFFFFFFFF);
    wr(DCD_OFF_CFG1, 32'h0);
    rd(DCD_OFF_IDENT, {DCD_REVISION, DCD_PART_IDENT});
    rd(DCD_OFF_CFG1, w1);
    apb(1'b1, 12'h020, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    $display("test read-only done");
    wr(DCD_OFF_CTRL, 32'h00003009);
    rd(DCD_OFF_CTRL, 32'h00000009);
    wr(DCD_OFF_UNLOCK, DCD_UNLOCK_KEY1);
    wr(DCD_OFF_UNLOCK, DCD_UNLOCK_KEY2);
    wr(DCD_OFF_REMAP, 32'h0000A5A5);
    wr(DCD_OFF_MODDIS, 32'h0000C3C3);
    wr(DCD_OFF_CTRL, 32'h00002004);
    rd(DCD_OFF_CTRL, 32'h00002004);
    chk({31'h0, trace_output_enable}, 32'h1);
    chk({31'h0, two_wire_tdo_use}, 32'h0);
    wr(DCD_OFF_REMAP, 32'h00005A5A);
    rd(DCD_OFF_REMAP, 32'h0000A5A5);
    chk(pin_remap_q, 32'h0000A5A5);
    wr(DCD_OFF_CTRL, 32'h00001000);
    rd(DCD_OFF_CTRL, 32'h00003000);
    chk({30'h0, pin_remap_lock, module_disable_lock}, 32'h3);
    wr(DCD_OFF_MODDIS, 32'h0);
    rd(DCD_OFF_MODDIS, 32'h0000C3C3);
    wr(DCD_OFF_CTRL, 32'h0);
    rd(DCD_OFF_CTRL, 32'h00002000);
    wr(DCD_OFF_MODDIS, 32'h0000000F);
    rd(DCD_OFF_MODDIS, 32'h0000000F);
    chk(module_disable_q, 32'h0000000F);
    wr(DCD_OFF_UNLOCK, 32'h0);
    wr(DCD_OFF_CTRL, 32'h00001000);
    rd(DCD_OFF_CTRL, 32'h00002000);
    rst({w3, w2, w1, w0}, 3);
    rd(DCD_OFF_CTRL, 32'h00000009);
    chk({30'h0, jtag_port_enable, two_wire_tdo_use}, {30'h0, w0[DCD_CFG0_JTAG], 1'b1});
    $display("test locks done");
    conclude();
  end
endmodule
